/* src/tbt_timer.sv */
// Tick timer top: APB control register, two dividers, tap select.
// Assumes APB3 master on core_clk; mode inputs are synchronous levels.
`timescale 1ns/100ps
`include "tbt_defines.svh"
module tbt_timer #(
  parameter int GEAR_W = `TBT_GEAR_DIV_W,
  parameter int LF_W = `TBT_LF_DIV_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources and operating mode
  input wire logic low_freq_clock,
  input wire logic low_freq_prescale_source,
  input wire logic slow_mode,
  input wire logic stop_entry,
  // Tick output
  output logic tick_interrupt
);

  logic tick_irq_enable_reg;
  tbt_pkg::tbt_sel_t tick_rate_select_reg;
  logic [GEAR_W-1:0] gear_taps;
  logic [LF_W-1:0] lf_taps;
  logic lf_rise;
  logic tap_now;
  logic tap_prev_reg;
  logic tap_fall;
  logic lf_mode;
  logic wr_en;
  logic addr_ok;
  logic [7:0] ctrl_view;
  logic [31:0] rd_next;
  logic tick_next;

  ////////////////////////////////////////////////////////////////////////
  // Dividers: gear chain every cycle, low-frequency chain per lf edge
  tbt_divider #(.WIDTH(GEAR_W)) u_gear_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_in(1'b1),
    .taps(gear_taps)
  );

  tbt_sync u_lf_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lf_clk_in(low_freq_clock),
    .lf_rise(lf_rise)
  );

  tbt_divider #(.WIDTH(LF_W)) u_lf_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_in(lf_rise),
    .taps(lf_taps)
  );

  ////////////////////////////////////////////////////////////////////////
  // Tap index helpers: bit k toggles at source/2^(k+1)
  function automatic int gear_tap_bit(input tbt_pkg::tbt_sel_t sel);
    case (sel)
      3'h0: gear_tap_bit = 21;
      3'h1: gear_tap_bit = 19;
      3'h2: gear_tap_bit = 14;
      3'h3: gear_tap_bit = 12;
      3'h4: gear_tap_bit = 11;
      3'h5: gear_tap_bit = 10;
      3'h6: gear_tap_bit = 9;
      default: gear_tap_bit = 7;
    endcase
  endfunction

  // Code 111 is reserved here; it yields -1, meaning no tap
  function automatic int lf_tap_bit(input tbt_pkg::tbt_sel_t sel);
    case (sel)
      3'h0: lf_tap_bit = 14;
      3'h1: lf_tap_bit = 12;
      3'h2: lf_tap_bit = 7;
      3'h3: lf_tap_bit = 5;
      3'h4: lf_tap_bit = 4;
      3'h5: lf_tap_bit = 3;
      3'h6: lf_tap_bit = 2;
      default: lf_tap_bit = -1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Source choice: slow mode always runs from the low-frequency clock
  assign lf_mode = slow_mode | low_freq_prescale_source;

  // Tap mux; reserved low-freq code holds the tap low, so no ticks
  always_comb begin
    int gb;
    int lb;
    gb = 0;
    lb = 0;
    tap_now = 1'b0;
    gb = gear_tap_bit(tick_rate_select_reg);
    lb = lf_tap_bit(tick_rate_select_reg);
    if (lf_mode) begin
      if (lb >= 0 && lb < LF_W) begin
        tap_now = lf_taps[lb];
      end
    end else if (gb < GEAR_W) begin
      tap_now = gear_taps[gb];
    end
  end

  // Falling edge tracked always, so enabling catches the next one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_prev_reg <= 1'b0;
    end else begin
      tap_prev_reg <= tap_now;
    end
  end

  assign tap_fall = tap_prev_reg & ~tap_now;

  ////////////////////////////////////////////////////////////////////////
  // Tick pulse: one core cycle per falling edge while enabled
  assign tick_next = tap_fall & tick_irq_enable_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_interrupt <= 1'b0;
    end else begin
      tick_interrupt <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, error on unmapped offsets
  assign addr_ok = (paddr == `TBT_CTRL_OFFSET) ||
                   (paddr == `TBT_STAT_OFFSET);
  assign wr_en = psel & penable & pwrite & (paddr == `TBT_CTRL_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Control register; stop entry beats a write to the enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_irq_enable_reg <= 1'(`TBT_CTRL_RESET >> `TBT_EN_BIT);
      tick_rate_select_reg <= '0;
    end else begin
      if (wr_en) begin
        tick_irq_enable_reg <= pwdata[`TBT_EN_BIT];
        tick_rate_select_reg <= pwdata[`TBT_SEL_MSB:0];
      end
      if (stop_entry) begin
        tick_irq_enable_reg <= 1'b0;
      end
    end
  end

  // Upper nibble forced to zero on read
  assign ctrl_view = {4'h0, tick_irq_enable_reg, tick_rate_select_reg};

  // Read data; status shows source mode and current tap level
  always_comb begin
    rd_next = 32'h0000_0000;
    if (paddr == `TBT_CTRL_OFFSET) begin
      rd_next = {24'h00_0000, ctrl_view};
    end else if (paddr == `TBT_STAT_OFFSET) begin
      rd_next = {30'h0000_0000, lf_mode, tap_now};
    end
  end

  // Registered read data, loaded in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_next;
    end
  end

endmodule

/* src/tbt_defines.svh */
// Constants for the tick timer: offsets, field positions, resets, counts.
// Assumes inclusion by bare name from the tick timer sources.
//
// Overview of operation
// - Control register bits 7 to 4 always read back as zero.
// - Low-frequency sourcing in normal/idle resyncs to gear clock, ticks jitter.
// - With enable set, each falling edge of selected tap raises a tick.
// - With enable clear, no tick request is raised.
// - Entering stop mode clears tick enable in hardware.
// - Divider runs regardless of enable; enabling never restarts it.
// - First tick comes at next tap falling edge, first interval may be short.
// - Control register: enable at bit 3, select at bits 2 to 0, reset zero.
// - Select picks gear taps 22,20,15,13,12,11,10,8 or low-freq taps.
`ifndef TBT_DEFINES_SVH
`define TBT_DEFINES_SVH

`define TBT_CTRL_OFFSET 12'h000
`define TBT_STAT_OFFSET 12'h004
`define TBT_EN_BIT 3
`define TBT_SEL_MSB 2
`define TBT_CTRL_RESET 8'h00
`define TBT_GEAR_DIV_W 22
`define TBT_LF_DIV_W 15
`define TBT_SYNC_STAGES 2

`endif

/* src/tbt_pkg.sv */
// Types shared by the tick timer modules.
// Assumes tbt_defines.svh is compiled alongside.
package tbt_pkg;

  typedef enum logic [2:0] {
    TBT_ST_IDLE = 3'b001,
    TBT_ST_SETUP = 3'b010,
    TBT_ST_ACCESS = 3'b100
  } tbt_apb_state_t;

  typedef logic [2:0] tbt_sel_t;

endpackage

/* src/tbt_divider.sv */
// Free-running divider chain for one clock source.
// Assumes tick_in is a one-cycle advance strobe on core_clk.
`timescale 1ns/100ps
module tbt_divider #(
  parameter int WIDTH = 22
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Advance strobe
  input wire logic tick_in,
  // Divider taps
  output logic [WIDTH-1:0] taps
);

  ////////////////////////////////////////////////////////////////////////
  // Never cleared by enable, so the phase is free running
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      taps <= '0;
    end else if (tick_in) begin
      taps <= taps + 1'b1;
    end
  end

endmodule

/* src/tbt_sync.sv */
// Two-stage synchroniser for the low-frequency clock level.
// Assumes lf_clk_in is a slow level asynchronous to core_clk.
`timescale 1ns/100ps
module tbt_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Async level in
  input wire logic lf_clk_in,
  // Rising edge of synchronised level
  output logic lf_rise
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  ////////////////////////////////////////////////////////////////////////
  // Resync adds up to a core cycle of jitter to ticks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= lf_clk_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Edge taken only between later stages
  assign lf_rise = stage2_reg & ~stage3_reg;

endmodule

/* verification/tbt_timer_properties.sv */
// Port-level checker for the tick timer.
// Assumes bind onto tbt_timer, one clock domain.
`timescale 1ns/100ps
module tbt_timer_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode and tick
  input wire logic low_freq_prescale_source,
  input wire logic slow_mode,
  input wire logic stop_entry,
  input wire logic tick_interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic en_h;
  logic [2:0] sel_h;
  logic acc;
  ////////////////////////////////////////////////////////////
  // Shadow of the control register; stop beats a write
  assign acc = psel && penable && paddr == 12'h000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      en_h <= 1'b0;
    else if (stop_entry)
      en_h <= 1'b0;
    else if (acc && pwrite)
      en_h <= pwdata[3];
  end
  // Select survives stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      sel_h <= 3'h0;
    else if (acc && pwrite)
      sel_h <= pwdata[2:0];
  end
  sequence s_quiet;
    !tick_interrupt [*8];
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_read_upper: assert property (acc && !pwrite |-> prdata[31:4] == 28'h0)
    else $error("upper bits not zero");
  chk_read_ctrl: assert property (acc && !pwrite |->
    prdata[3:0] == {$past(en_h), $past(sel_h)}) else $error("ctrl mismatch");
  chk_err_map: assert property (psel && penable |->
    pslverr == (paddr != 12'h000 && paddr != 12'h004)) else $error("pslverr");
  chk_tick_gap: assert property (tick_interrupt |=> s_quiet)
    else $error("tick not a lone pulse");
  chk_tick_gate: assert property (tick_interrupt |-> $past(en_h))
    else $error("tick while disabled");
  chk_stop_clear: assert property (stop_entry |=> ##1 !tick_interrupt)
    else $error("tick after stop");
  chk_lf_rsvd: assert property ($past(low_freq_prescale_source |
    slow_mode) && $past(sel_h) == 3'h7 |-> !tick_interrupt)
    else $error("reserved tick");
endmodule
bind tbt_timer tbt_timer_properties u_chk (.core_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .low_freq_prescale_source, .slow_mode, .stop_entry, .tick_interrupt);

/* verification/tbt_timer_tb.sv */
// Self-checking bench for the tick timer.
// Assumes default divider widths; low-freq clock runs free.
`timescale 1ns/100ps
module tbt_timer_tb;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic low_freq_clock, lf_src, slow_mode, stop_entry, tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int errors, n_tests, n, i, p, t, cyc;
  tbt_timer DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .low_freq_clock,
    .low_freq_prescale_source(lf_src), .slow_mode, .stop_entry,
    .tick_interrupt(tick));
  ////////////////////////////////////////////////////////////
  // Clocks; odd low-freq half-period keeps phases unrelated
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    low_freq_clock = 1'b0;
    forever #103 low_freq_clock = ~low_freq_clock;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer; bounded wait on pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    chk(k < 20, 32'h1);
    if (k >= 20) begin
      results;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles to next tick; n equals lim if none
  task automatic gap(input int lim);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (tick !== 1'b1 && n < lim);
  endtask
  task automatic results;
    $display("Checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, lf_src, slow_mode, stop_entry} = 7'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, 12'h000, 32'hfff5);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h5);
    apb(1'b1, 12'h008, 32'hf);
    chk(e, 32'h1);
    apb(1'b1, 12'h004, 32'hf);
    chk(e, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h5);
    // Gear taps; re-enable must keep divider phase
    for (i = 7; i >= 4; i--) begin
      p = (i == 7) ? 256 : 1 << (16 - i);
      apb(1'b1, 12'h000, i);
      apb(1'b1, 12'h000, i | 8);
      gap(p + 1);
      t = cyc;
      apb(1'b1, 12'h000, i);
      repeat (40) @(negedge core_clk);
      apb(1'b1, 12'h000, i | 8);
      gap(p + 1);
      chk((cyc - t) % p, 32'h0);
      gap(p + 2);
      chk(n, p);
      apb(1'b1, 12'h000, i);
      gap(2 * p);
      chk(n, 2 * p);
    end
    apb(1'b1, 12'h000, 32'hf);
    stop_entry <= 1'b1;
    @(posedge core_clk);
    stop_entry <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h7);
    // Low-freq sourcing, then slow mode
    for (i = 0; i < 2; i++) begin
      lf_src <= !i[0];
      slow_mode <= i[0];
      apb(1'b1, 12'h000, 32'h6);
      apb(1'b1, 12'h000, 32'he);
      gap(200);
      gap(200);
      chk(n >= 78 && n <= 87, 32'h1);
      apb(1'b1, 12'h000, 32'h6);
    end
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b1, 12'h000, 32'hf);
    gap(300);
    chk(n, 32'd300);
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h2);
    results;
  end
endmodule
